// ==== design/gd_config_regs.sv ====
/*
   gate drive configuration registers: source current selection, hold current,
   spi direct gate drive and per-phase force-low. registers are accessed by an
   spi front end through a simple request port; pwm_mode and the global enable
   come from elsewhere in the device. one clock, synchronous active-low reset.
*/
//
// Operation
// [R01] cfg 0, sink code 0..0x23: source follows sink through ratio field
// [R02] cfg 0, sink code 0x24..0x2C: source uses same code as sink
// [R03] cfg 1: source from dedicated registers, ratio ignored
// [R04] host changes hold select only while driver is disabled
// [R05] hold select 0 gives 500/1000 mA, 1 gives 260/260 mA
// [R06] direct bits drive gates only in spi mode with driver enabled
// [R07] direct bit 0 drives gate low, 1 drives it high
// [R08] cleared phase enable forces both gates low with pull-down at once
// [R09] clearing a phase enable leaves global enable untouched
// [R10] phase force-low acts in every pwm mode while driver enabled
// [R11] phase enables reset to 1; set means gates follow pwm mode
// [R12] high-side source field used only when cfg is 1
// [R13] low-side source field used only when cfg is 1
// [R14] ratio 00/01/10/11 gives 1x/0.75x/0.5x/0.25x of sink
// [R15] cleared phase enable overrides direct bits and pwm inputs
`timescale 1ns/1ps
`include "gd_defs.svh"

module gd_config_regs (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // register access
   input  gd_pkg::gd_reg_req_t     reg_req,
   output logic [15:0]             reg_rdata,
   // drive control from the rest of the device
   input  wire logic               driver_global_enable,
   input  wire logic [2:0]         pwm_mode,
   input  gd_pkg::gd_gate_t        pwm_gates,
   // gate commands
   output gd_pkg::gd_gate_t        gate_out,
   output logic [2:0]              gate_pulldown,
   // current settings to the analog stages
   output gd_pkg::gd_drive_t       high_side_drive,
   output gd_pkg::gd_drive_t       low_side_drive,
   output logic                    hold_current_select,
   output logic [11:0]             hold_pullup_ma,
   output logic [11:0]             hold_pulldown_ma
);

   logic [15:0]       direct_ctrl;
   logic [15:0]       phase_ctrl;
   logic [15:0]       source_ctrl;
   logic [15:0]       sink_ctrl;
   gd_pkg::gd_gate_t  next_gate;
   logic [2:0]        next_pulldown;
   gd_pkg::gd_drive_t next_drive [2];
   logic              spi_mode;

   // register writes, one process per register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         direct_ctrl <= `GD_RST_DIRECT;
      end else if (reg_req.wr && reg_req.addr == `GD_ADDR_DIRECT) begin
         direct_ctrl <= reg_req.wdata & `GD_MASK_DIRECT;
      end
   end

   // only the phase bits live here; global enable is never written by it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_ctrl <= `GD_RST_PHASE;                               // [R11]
      end else if (reg_req.wr && reg_req.addr == `GD_ADDR_PHASE) begin
         phase_ctrl <= reg_req.wdata & `GD_MASK_PHASE;              // [R09]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         source_ctrl <= `GD_RST_SOURCE;
      end else if (reg_req.wr && reg_req.addr == `GD_ADDR_SOURCE) begin
         source_ctrl <= reg_req.wdata & `GD_MASK_SOURCE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sink_ctrl <= `GD_RST_SINK;
      end else if (reg_req.wr && reg_req.addr == `GD_ADDR_SINK) begin
         sink_ctrl <= reg_req.wdata & `GD_MASK_SINK;
      end
   end

   // read data one cycle after the request; unmapped offsets read zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_req.rd) begin
         if (reg_req.addr == `GD_ADDR_DIRECT) begin
            reg_rdata <= direct_ctrl;
         end else if (reg_req.addr == `GD_ADDR_PHASE) begin
            reg_rdata <= phase_ctrl;
         end else if (reg_req.addr == `GD_ADDR_SOURCE) begin
            reg_rdata <= source_ctrl;
         end else if (reg_req.addr == `GD_ADDR_SINK) begin
            reg_rdata <= sink_ctrl;
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // source current per side, side 1 = high, side 0 = low
   for (genvar s = 0; s < 2; s++) begin : g_side
      gd_source_sel u_sel (
         .cfg_sel        (direct_ctrl[`GD_BIT_CFG_SEL]),
         .sink_code      (sink_ctrl[s*8 +: 6]),
         .ratio          (sink_ctrl[s*8 + `GD_RATIO_OFFSET +: 2]),
         .dedicated_code (source_ctrl[s*8 +: 6]),
         .drive          (next_drive[s])
      );
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         high_side_drive <= '0;
         low_side_drive  <= '0;
      end else begin
         high_side_drive <= next_drive[1];
         low_side_drive  <= next_drive[0];
      end
   end

   // hold current; software keeps the driver off while changing it, so no
   // glitch filtering is done here
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hold_current_select <= 1'b0;
         hold_pullup_ma      <= `GD_HOLD_UP_STRONG;
         hold_pulldown_ma    <= `GD_HOLD_DN_STRONG;
      end else begin
         hold_current_select <= direct_ctrl[`GD_BIT_HOLD_SEL];      // [R04]
         if (direct_ctrl[`GD_BIT_HOLD_SEL]) begin
            hold_pullup_ma   <= `GD_HOLD_WEAK;                      // [R05]
            hold_pulldown_ma <= `GD_HOLD_WEAK;
         end else begin
            hold_pullup_ma   <= `GD_HOLD_UP_STRONG;
            hold_pulldown_ma <= `GD_HOLD_DN_STRONG;
         end
      end
   end

   // gate selection per phase, phase index 2 = a, 0 = c
   assign spi_mode = (pwm_mode == `GD_MODE_SPI_DRIVE);

   for (genvar p = 0; p < 3; p++) begin : g_phase
      always_comb begin
         next_gate.high[p]  = 1'b0;
         next_gate.low[p]   = 1'b0;
         next_pulldown[p]   = 1'b0;
         if (!driver_global_enable) begin
            // driver off: the analog shutdown path owns the gates
            next_gate.high[p] = 1'b0;
         end else if (!phase_ctrl[p]) begin
            next_pulldown[p]  = 1'b1;                               // [R08]
         end else if (spi_mode) begin
            next_gate.high[p] = direct_ctrl[`GD_LSB_DIRECT_HIGH + p]; // [R06]
            next_gate.low[p]  = direct_ctrl[p];                     // [R07]
         end else begin
            next_gate.high[p] = pwm_gates.high[p];                  // [R11]
            next_gate.low[p]  = pwm_gates.low[p];
         end
      end
   end

   // force-low ranks above spi and pwm in the chain above, in any mode
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gate_out      <= '0;
         gate_pulldown <= 3'h0;
      end else begin
         gate_out      <= next_gate;                                // [R15]
         gate_pulldown <= next_pulldown;                            // [R10]
      end
   end

   // checks
   sequence s_phase_a_off;
      driver_global_enable && !phase_ctrl[2];
   endsequence

   sequence s_phase_a_low;
      !gate_out.high[2] && !gate_out.low[2] && gate_pulldown[2];
   endsequence

   property p_ratio_path;
      @(posedge clk_sys) disable iff (!rst_n)
      !direct_ctrl[9] && sink_ctrl[13:8] <= 6'h23 |=>
         high_side_drive.use_ratio && high_side_drive.code == $past(sink_ctrl[13:8])
         && high_side_drive.ratio == $past(sink_ctrl[15:14]);
   endproperty
   a_ratio_path: assert property (p_ratio_path) else $error("ratio path wrong"); // [R01]

   property p_same_code;
      @(posedge clk_sys) disable iff (!rst_n)
      !direct_ctrl[9] && sink_ctrl[5:0] >= 6'h24 && sink_ctrl[5:0] <= 6'h2C |=>
         !low_side_drive.use_ratio && low_side_drive.code == $past(sink_ctrl[5:0]);
   endproperty
   a_same_code: assert property (p_same_code) else $error("same code wrong"); // [R02]

   property p_dedicated;
      @(posedge clk_sys) disable iff (!rst_n)
      direct_ctrl[9] |=> !high_side_drive.use_ratio && !low_side_drive.use_ratio
         && high_side_drive.code == $past(source_ctrl[13:8])
         && low_side_drive.code == $past(source_ctrl[5:0]);
   endproperty
   a_dedicated: assert property (p_dedicated) else $error("dedicated path wrong"); // [R03]

   property p_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      direct_ctrl[8] |=> hold_pullup_ma == 12'h104 && hold_pulldown_ma == 12'h104;
   endproperty
   a_hold: assert property (p_hold) else $error("hold current wrong"); // [R05]

   property p_spi_drive;
      @(posedge clk_sys) disable iff (!rst_n)
      driver_global_enable && pwm_mode == 3'h5 && phase_ctrl[2] |=>
         gate_out.high[2] == $past(direct_ctrl[5]) && gate_out.low[2] == $past(direct_ctrl[2]);
   endproperty
   a_spi_drive: assert property (p_spi_drive) else $error("spi drive wrong"); // [R06]

   property p_force_low;
      @(posedge clk_sys) disable iff (!rst_n)
      s_phase_a_off |=> s_phase_a_low;
   endproperty
   a_force_low: assert property (p_force_low) else $error("phase a not forced low"); // [R08]

   property p_force_low_held;
      @(posedge clk_sys) disable iff (!rst_n)
      // gates lag their cause by one edge, so the first low cycle overlaps the last cycle of the cause
      s_phase_a_off [*2] |-> s_phase_a_low [*2];
   endproperty
   a_force_low_held: assert property (p_force_low_held) else $error("force low dropped"); // [R10]

   property p_phase_reset;
      @(posedge clk_sys) disable iff (!rst_n)
      !$past(rst_n) |-> phase_ctrl[2:0] == 3'h7;
   endproperty
   a_phase_reset: assert property (p_phase_reset) else $error("phase reset wrong"); // [R11]

   property p_follow_pwm;
      @(posedge clk_sys) disable iff (!rst_n)
      driver_global_enable && pwm_mode != 3'h5 && phase_ctrl[0] |=>
         gate_out.high[0] == $past(pwm_gates.high[0]) && !gate_pulldown[0];
   endproperty
   a_follow_pwm: assert property (p_follow_pwm) else $error("pwm not followed"); // [R11]

endmodule

// ==== design/gd_source_sel.sv ====
/*
   resolves the source (pull-up) peak current setting of one gate driver side
   from the sink code, the ratio field and the dedicated source code.
   purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`include "gd_defs.svh"

module gd_source_sel (
   // selection inputs
   input  wire logic             cfg_sel,
   input  wire logic [5:0]       sink_code,
   input  wire logic [1:0]       ratio,
   input  wire logic [5:0]       dedicated_code,
   // resolved setting
   output gd_pkg::gd_drive_t     drive
);

   always_comb begin
      drive = '0;
      if (cfg_sel) begin
         // ratio field plays no part here
         drive.code      = dedicated_code;                          // [R03]
         drive.ratio     = 2'h0;                                    // [R12]
         drive.use_ratio = 1'b0;                                    // [R13]
      end else if (sink_code <= `GD_RATIO_MAX_CODE) begin
         drive.code      = sink_code;                               // [R01]
         drive.ratio     = ratio;                                   // [R14]
         drive.use_ratio = 1'b1;
      end else begin
         // codes above the last defined one are treated like the strong range
         drive.code      = sink_code;                               // [R02]
         drive.ratio     = 2'h0;
         drive.use_ratio = 1'b0;
      end
   end

endmodule

// ==== dv/gd_config_regs_tb.sv ====
/*
   self-checking bench of the gate drive configuration registers.
   assumes gd_host_model speaks the register port and the block has one clock.
*/
`timescale 1ns/1ps

module gd_config_regs_tb;
   typedef struct packed {
      logic [15:0] direct;
      logic [2:0]  phase;
      logic        en;
      logic [2:0]  mode;
      logic [5:0]  pwm;
      logic [5:0]  gates;
      logic [2:0]  pd;
   } gd_row_t;

   logic                clk_sys = 1'b0;
   logic                rst_n = 1'b0;
   logic                driver_global_enable = 1'b0;
   logic [2:0]          pwm_mode = 3'h0;
   gd_pkg::gd_gate_t    pwm_gates = '0;
   gd_pkg::gd_reg_req_t reg_req;
   logic [15:0]         reg_rdata;
   gd_pkg::gd_gate_t    gate_out;
   logic [2:0]          gate_pulldown;
   gd_pkg::gd_drive_t   high_side_drive;
   gd_pkg::gd_drive_t   low_side_drive;
   logic                hold_current_select;
   logic [11:0]         hold_pullup_ma;
   logic [11:0]         hold_pulldown_ma;
   int                  errors = 0;
   int                  samples_checked = 0;
   gd_row_t             rows [8];
   logic [15:0]         masks [6] = '{16'h0000, 16'h033F, 16'h0007, 16'h3F3F, 16'hFFFF, 16'h0000};
   logic [5:0]          sinks [5] = '{6'h00, 6'h23, 6'h24, 6'h2C, 6'h3F};

   always #20 clk_sys = ~clk_sys;

   gd_host_model host (.clk_sys, .rst_n, .driver_global_enable, .reg_rdata, .reg_req);

   gd_config_regs dut (.clk_sys, .rst_n, .reg_req, .reg_rdata, .driver_global_enable,
      .pwm_mode, .pwm_gates, .gate_out, .gate_pulldown, .high_side_drive, .low_side_drive,
      .hold_current_select, .hold_pullup_ma, .hold_pulldown_ma);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask

   // two cycles: the register has already landed in wr, outputs land on the first edge
   task automatic settle();
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic do_reset();
      @(negedge clk_sys);
      rst_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
   endtask

   function automatic gd_pkg::gd_drive_t exp_drv(input logic c, input logic [5:0] s,
                                                 input logic [1:0] r, input logic [5:0] d);
      if (c) return '{d, 2'h0, 1'b0};
      if (s <= 6'h23) return '{s, r, 1'b1};
      return '{s, 2'h0, 1'b0};
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      rows = '{'{16'h0020, 3'h7, 1'b1, 3'h5, 6'h00, 6'h20, 3'h0},
               '{16'h003F, 3'h7, 1'b1, 3'h5, 6'h00, 6'h3F, 3'h0},
               '{16'h003F, 3'h7, 1'b0, 3'h5, 6'h00, 6'h00, 3'h0},
               '{16'h003F, 3'h7, 1'b1, 3'h4, 6'h11, 6'h11, 3'h0},
               '{16'h003F, 3'h3, 1'b1, 3'h5, 6'h00, 6'h1B, 3'h4},
               '{16'h0000, 3'h6, 1'b1, 3'h2, 6'h3F, 6'h36, 3'h1},
               '{16'h0000, 3'h0, 1'b1, 3'h0, 6'h3F, 6'h00, 3'h7},
               '{16'h0000, 3'h0, 1'b0, 3'h0, 6'h3F, 6'h00, 3'h0}};
      do_reset();
      chk_reg(8'h23, 16'h0000);
      chk_reg(8'h24, 16'h0007);
      chk({4'h0, hold_pullup_ma}, 16'h01F4);
      // masks cover reserved bits and the unmapped neighbours
      for (int i = 0; i < 6; i++) begin
         host.wr(8'h22 + 8'(i), 16'hFFFF);
         chk_reg(8'h22 + 8'(i), masks[i]);
      end
      $display("test register access done");
      do_reset();
      chk_reg(8'h24, 16'h0007);
      chk_reg(8'h26, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         host.wr(8'h23, rows[i].direct);
         host.wr(8'h24, {13'h0000, rows[i].phase});
         driver_global_enable = rows[i].en;
         pwm_mode = rows[i].mode;
         pwm_gates = rows[i].pwm;
         settle();
         chk({10'h000, gate_out}, {10'h000, rows[i].gates});
         chk({13'h0000, gate_pulldown}, {13'h0000, rows[i].pd});
      end
      $display("test gate table done");
      host.wr(8'h23, 16'h0024);
      host.wr(8'h24, 16'h0005);
      driver_global_enable = 1'b1;
      pwm_gates = 6'h3F;
      for (int m = 0; m < 8; m++) begin
         pwm_mode = 3'(m);
         settle();
         chk({10'h000, gate_out}, (m == 5) ? 16'h0024 : 16'h002D);
         chk({13'h0000, gate_pulldown}, 16'h0002);
      end
      $display("test every mode done");
      host.wr(8'h25, 16'h2A15);
      for (int c = 0; c < 2; c++) begin
         host.wr(8'h23, {6'h00, 1'(c), 9'h000});
         foreach (sinks[i]) begin
            host.wr(8'h26, {2'(i), sinks[i], ~2'(i), sinks[i]});
            settle();
            chk({7'h00, high_side_drive},
                {7'h00, exp_drv(1'(c), sinks[i], 2'(i), 6'h2A)});
            chk({7'h00, low_side_drive},
                {7'h00, exp_drv(1'(c), sinks[i], ~2'(i), 6'h15)});
         end
      end
      $display("test source current done");
      host.wr(8'h23, 16'h0100);
      settle();
      chk({15'h0000, hold_current_select}, 16'h0000);
      driver_global_enable = 1'b0;
      host.wr(8'h23, 16'h0100);
      settle();
      chk({15'h0000, hold_current_select}, 16'h0001);
      chk({4'h0, hold_pullup_ma}, 16'h0104);
      chk({4'h0, hold_pulldown_ma}, 16'h0104);
      host.wr(8'h23, 16'h0000);
      settle();
      chk({4'h0, hold_pullup_ma}, 16'h01F4);
      chk({4'h0, hold_pulldown_ma}, 16'h03E8);
      $display("test hold current done");
      close_out();
   end
endmodule

// ==== dv/gd_host_model.sv ====
/*
   spi host stand-in that issues register requests to the gate drive block.
   assumes requests are taken on the rising edge of clk_sys.
*/
`timescale 1ns/1ps

module gd_host_model (
   // clock, reset and device state
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          driver_global_enable,
   input  wire logic [15:0]   reg_rdata,
   // request to the block
   output gd_pkg::gd_reg_req_t reg_req
);
   logic hold_shadow;

   initial begin
      reg_req = '0;
      hold_shadow = 1'b0;
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         hold_shadow = 1'b0;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      // hold select only moves while the driver is off
      if (a == 8'h23 && driver_global_enable) begin
         v[8] = hold_shadow;
      end
      if (a == 8'h23) begin
         hold_shadow = v[8];
      end
      @(negedge clk_sys);
      reg_req = '{a, 1'b1, 1'b0, v};
      @(negedge clk_sys);
      reg_req = '{~a, 1'b0, 1'b0, ~v};
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      reg_req = '{a, 1'b0, 1'b1, 16'hA5A5};
      @(negedge clk_sys);
      reg_req = '{~a, 1'b0, 1'b0, 16'h5A5A};
      d = reg_rdata;
   endtask
endmodule

// ==== inc/gd_defs.svh ====
/*
   register offsets, field positions, reset values and hold-current levels of the
   gate drive configuration block. assumes 16-bit registers at the listed offsets.
*/
`ifndef GD_DEFS_SVH
`define GD_DEFS_SVH

// register offsets
`define GD_ADDR_DIRECT     8'h23
`define GD_ADDR_PHASE      8'h24
`define GD_ADDR_SOURCE     8'h25
`define GD_ADDR_SINK       8'h26

// reset values
`define GD_RST_DIRECT      16'h0000
`define GD_RST_PHASE       16'h0007
`define GD_RST_SOURCE      16'h0000
`define GD_RST_SINK        16'h0000

// writable bits; everything else reads as zero
`define GD_MASK_DIRECT     16'h033F
`define GD_MASK_PHASE      16'h0007
`define GD_MASK_SOURCE     16'h3F3F
`define GD_MASK_SINK       16'hFFFF

// field positions
`define GD_BIT_CFG_SEL     9
`define GD_BIT_HOLD_SEL    8
`define GD_LSB_DIRECT_HIGH 3
`define GD_LSB_HIGH_SIDE   8
`define GD_RATIO_OFFSET    6

// pwm mode code of spi gate drive mode
`define GD_MODE_SPI_DRIVE  3'h5

// sink code ranges
`define GD_RATIO_MAX_CODE  6'h23
`define GD_SAME_MIN_CODE   6'h24
`define GD_SAME_MAX_CODE   6'h2C

// hold currents in mA
`define GD_HOLD_UP_STRONG  12'h1F4
`define GD_HOLD_DN_STRONG  12'h3E8
`define GD_HOLD_WEAK       12'h104

`endif

// ==== inc/gd_pkg.sv ====
/*
   types shared by the gate drive configuration block.
   assumes gd_defs.svh supplies all numeric constants.
*/
package gd_pkg;

   // one register access from the spi front end
   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } gd_reg_req_t;

   // gate levels, bit 2 = phase a, bit 0 = phase c
   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } gd_gate_t;

   // resolved source current setting of one side
   typedef struct packed {
      logic [5:0] code;
      logic [1:0] ratio;
      logic       use_ratio;
   } gd_drive_t;

endpackage
